// >>> pgc_serial_gain_control.sv
// Serial control port and gain/power register of the gain amplifier.
`timescale 1ns/10ps

module pgc_serial_gain_control
  import pgc_pkg::*;
(
  // System clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Serial link
  input wire logic serial_clock_in,
  input wire logic chip_select_n_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_n_out,
  // Transmit control pin
  input wire logic transmit_enable_in,
  // Amplifier controls
  output logic [5:0] gain_code_out,
  output logic [1:0] power_code_out,
  output logic [7:0] bias_level_out,
  output logic amp_powered_out,
  output logic update_pulse_out
);
  // ==========================================================
  // Link domain: shifter and register, on the serial clock.
  // Select high acts as an asynchronous frame reset for the counter and shifter; it is
  // the frame's own signal, so nothing here relies on edges outside frames.
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] hdr_q;
  logic [3:0] hdr_d;
  logic [7:0] dat_q;
  logic [7:0] dat_d;
  pgc_setting_t reg_q;
  pgc_setting_t reg_d;
  logic tog_q;
  logic tog_d;
  logic frame_rst;
  logic link_rst_q;
  logic [11:0] shift_word;

  assign frame_rst = chip_select_n_in;
  assign shift_word = {hdr_q, dat_q};

  always_comb
  begin
    cnt_d = cnt_q;
    hdr_d = hdr_q;
    dat_d = dat_q;
    reg_d = reg_q;
    tog_d = tog_q;
    if (cnt_q < PGC_APPLY_EDGE)
    begin
      cnt_d = cnt_q + 4'h1;
      // Bits enter MSB first, header then data.
      {hdr_d, dat_d} = {shift_word[10:0], serial_data_in};
    end
    // Twelfth rising edge of a write to address zero applies the codes.
    // Before that edge the direction bit sits in hdr_q[2] and the address
    // straddles hdr_q[1:0] and dat_q[7].
    if (cnt_q == PGC_APPLY_EDGE - 4'h1 && !hdr_q[2] &&
        {hdr_q[1:0], dat_q[7]} == PGC_ADDR_GAIN_POWER)
    begin
      reg_d = {dat_q[6:0], serial_data_in};
      tog_d = ~tog_q;
    end
  end

  // Partial frames never reach the apply edge, so the register holds.
  always_ff @(posedge serial_clock_in or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      cnt_q <= 4'h0;
      hdr_q <= 4'h0;
      dat_q <= 8'h00;
    end
    else
    begin
      cnt_q <= cnt_d;
      hdr_q <= hdr_d;
      dat_q <= dat_d;
    end
  end

  // The register survives frame ends; it is cleared only by system reset,
  // carried into this domain as a synchronised level.
  always_ff @(posedge serial_clock_in)
  begin
    if (link_rst_q)
    begin
      reg_q <= PGC_GAIN_POWER_RESET;
      tog_q <= 1'b0;
    end
    else
    begin
      reg_q <= reg_d;
      tog_q <= tog_d;
    end
  end

  // Reset level held until seen on the serial clock side.
  logic link_rst_meta_q;
  always_ff @(posedge serial_clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      link_rst_meta_q <= 1'b1;
      link_rst_q <= 1'b1;
    end
    else
    begin
      link_rst_meta_q <= 1'b0;
      link_rst_q <= link_rst_meta_q;
    end
  end

  // ==========================================================
  // Read data driver, updated on falling serial clock edges.
  logic [7:0] rd_q;
  logic [7:0] rd_d;
  logic oe_n_q;
  logic oe_n_d;
  logic [2:0] rd_addr;

  // After four shifts the header lies in the low bits of the shifter.
  assign rd_addr = dat_q[2:0];

  always_comb
  begin
    rd_d = rd_q;
    oe_n_d = oe_n_q;
    if (cnt_q == PGC_HDR_LAST_EDGE && dat_q[3])
    begin
      // Header complete on a read: load and present the MSB.
      rd_d = (rd_addr == PGC_ADDR_GAIN_POWER) ? reg_q : PGC_UNMAPPED_READ;
      oe_n_d = 1'b0;
    end
    else if (cnt_q > PGC_HDR_LAST_EDGE && !oe_n_q)
    begin
      rd_d = {rd_q[6:0], 1'b0};
    end
  end

  always_ff @(negedge serial_clock_in or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      rd_q <= 8'h00;
      oe_n_q <= 1'b1;
    end
    else
    begin
      rd_q <= rd_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign serial_data_out = rd_q[7];
  assign serial_data_oe_n_out = oe_n_q;

  // ==========================================================
  // Crossing into the system clock: toggle event plus stable setting.
  logic tog_sync;
  logic tog_seen_q;
  logic tog_seen_d;
  logic transmit_enable_sync;
  pgc_setting_t set_q;
  pgc_setting_t set_d;
  logic upd_q;
  logic upd_d;

  pgc_sync #(
    .WIDTH(2)
  ) u_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .async_in({tog_q, transmit_enable_in}),
    .sync_out({tog_sync, transmit_enable_sync})
  );

  // The setting is stable for many system cycles once the toggle lands.
  always_comb
  begin
    tog_seen_d = tog_sync;
    set_d = set_q;
    upd_d = 1'b0;
    if (tog_sync != tog_seen_q)
    begin
      set_d = reg_q;
      upd_d = 1'b1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      tog_seen_q <= 1'b0;
      set_q <= PGC_GAIN_POWER_RESET;
      upd_q <= 1'b0;
    end
    else
    begin
      tog_seen_q <= tog_seen_d;
      set_q <= set_d;
      upd_q <= upd_d;
    end
  end

  assign gain_code_out = set_q.gain_code;
  assign power_code_out = set_q.power_code;
  assign update_pulse_out = upd_q;

  // ==========================================================
  // Output stage bias.
  pgc_bias u_bias (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .setting_in(set_q),
    .tx_on_in(transmit_enable_sync),
    .bias_level_out(bias_level_out),
    .amp_powered_out(amp_powered_out)
  );
endmodule

// >>> pgc_pkg.sv
// Package with constants and types of the serial gain-control block.
package pgc_pkg;
  // ==========================================================
  // Frame layout
  localparam int unsigned PGC_FRAME_BITS = 12;
  localparam int unsigned PGC_HDR_BITS = 4;
  localparam int unsigned PGC_ADDR_BITS = 3;
  localparam int unsigned PGC_DATA_BITS = 8;
  localparam logic [3:0] PGC_APPLY_EDGE = 4'hC;
  localparam logic [3:0] PGC_HDR_LAST_EDGE = 4'h4;
  // ==========================================================
  // Register map and fields
  localparam logic [2:0] PGC_ADDR_GAIN_POWER = 3'h0;
  localparam logic [7:0] PGC_GAIN_POWER_RESET = 8'h00;
  localparam int unsigned PGC_POWER_MSB = 7;
  localparam int unsigned PGC_POWER_LSB = 6;
  localparam int unsigned PGC_GAIN_MSB = 5;
  localparam int unsigned PGC_GAIN_LSB = 0;
  localparam logic [7:0] PGC_UNMAPPED_READ = 8'h00;
  // ==========================================================
  // Amplifier setting
  typedef struct packed {
    logic [1:0] power_code;
    logic [5:0] gain_code;
  } pgc_setting_t;
  // One-cycle event carried across domains as a toggle.
  typedef struct packed {
    logic toggle;
    pgc_setting_t setting;
  } pgc_update_t;
endpackage

// >>> pgc_sync.sv
// Two-flop level synchroniser.
`timescale 1ns/10ps
module pgc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("WIDTH must be at least one.");
    end
  end

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// >>> pgc_bias.sv
// Bias-level encoder for the amplifier output stage.
`timescale 1ns/10ps
module pgc_bias
  import pgc_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Setting and transmit state
  input wire pgc_pkg::pgc_setting_t setting_in,
  input wire logic tx_on_in,
  // Drive to the amplifier
  output logic [7:0] bias_level_out,
  output logic amp_powered_out
);
  logic [7:0] bias_q;
  logic [7:0] bias_d;
  logic pwr_q;
  logic pwr_d;

  // Bias grows with the power code and, within it, with the gain code.
  always_comb
  begin
    bias_d = {setting_in.power_code, setting_in.gain_code};
    pwr_d = tx_on_in;
    if (!tx_on_in)
    begin
      bias_d = 8'h00;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      bias_q <= 8'h00;
      pwr_q <= 1'b0;
    end
    else
    begin
      bias_q <= bias_d;
      pwr_q <= pwr_d;
    end
  end

  assign bias_level_out = bias_q;
  assign amp_powered_out = pwr_q;
endmodule

// >>> pgc_props.sv
// Checker on the ports of the serial gain-control block.
`timescale 1ns/10ps
module pgc_props
  import pgc_pkg::*;
(
  // Watched ports
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic serial_clock_in,
  input wire logic chip_select_n_in,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_n_out,
  input wire logic transmit_enable_in,
  input wire logic [5:0] gain_code_out,
  input wire logic [1:0] power_code_out,
  input wire logic [7:0] bias_level_out,
  input wire logic amp_powered_out,
  input wire logic update_pulse_out
);
  logic [3:0] n_q;
  logic [3:0] h_q;
  logic [7:0] s;
  logic on;
  assign s = {power_code_out, gain_code_out};
  assign on = transmit_enable_in && amp_powered_out && !update_pulse_out;
  // Counts rising link edges and keeps the header of the frame.
  always_ff @(posedge serial_clock_in or posedge chip_select_n_in)
  begin
    if (chip_select_n_in)
    begin
      n_q <= 4'h0;
      h_q <= 4'h0;
    end
    else
    begin
      if (n_q < 4'hC)
        n_q <= n_q + 4'h1;
      if (n_q < 4'h4)
        h_q <= {h_q[2:0], serial_data_in};
    end
  end
  property p_pon;
    @(posedge clock_in) disable iff (rst_in) transmit_enable_in [*5] |-> amp_powered_out;
  endproperty
  a_pon: assert property (p_pon) else $error("amplifier not powered");
  property p_poff;
    @(posedge clock_in) disable iff (rst_in) !transmit_enable_in [*5] |-> !amp_powered_out;
  endproperty
  a_poff: assert property (p_poff) else $error("amplifier still powered");
  property p_boff;
    @(posedge clock_in) disable iff (rst_in)
      (!transmit_enable_in && !amp_powered_out) [*4] |-> bias_level_out == 8'h00;
  endproperty
  a_boff: assert property (p_boff) else $error("bias not zero");
  property p_bon;
    @(posedge clock_in) disable iff (rst_in) on [*4] |-> bias_level_out == s;
  endproperty
  a_bon: assert property (p_bon) else $error("bias wrong");
  property p_pulse;
    @(posedge clock_in) disable iff (rst_in) update_pulse_out |=> !update_pulse_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  property p_idle;
    @(posedge clock_in) disable iff (rst_in)
      chip_select_n_in && $past(chip_select_n_in) |-> serial_data_oe_n_out;
  endproperty
  a_idle: assert property (p_idle) else $error("driver on while idle");
  property p_hdr;
    @(posedge serial_clock_in) disable iff (chip_select_n_in) !h_q[3] |-> serial_data_oe_n_out;
  endproperty
  a_hdr: assert property (p_hdr) else $error("driver on too early");
  property p_rd;
    @(posedge serial_clock_in) disable iff (chip_select_n_in)
      h_q[3] && n_q >= 4'h4 && n_q <= 4'hB |-> !serial_data_oe_n_out &&
      serial_data_out == ((h_q[2:0] == 3'h0) ? s[4'hB - n_q] : 1'b0);
  endproperty
  a_rd: assert property (p_rd) else $error("read bit wrong");
endmodule

bind pgc_serial_gain_control pgc_props u_props (.*);

// >>> pgc_host.sv
// Host model that sends frames on the serial port.
`timescale 1ns/10ps
module pgc_host (
  // Serial port
  output logic sclk_out,
  output logic cs_n_out,
  output logic sda_out,
  input wire logic sda_in
);
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sda_out = 1'b0;
  end
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      #3 sclk_out = 1'b1;
      #3 sclk_out = 1'b0;
    end
  endtask
  // A released line shows a pattern that changes every bit.
  task automatic frame(input logic rw, input logic [2:0] a, input logic [7:0] d,
    input int n, output logic [7:0] q);
    logic [11:0] w;
    w = {rw, a, d};
    q = 8'h00;
    #6 cs_n_out = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      if (rw && i > 3)
        sda_out = ~sda_out;
      else
        sda_out = w[11 - i];
      #3 sclk_out = 1'b1;
      if (i > 3)
        q[11 - i] = sda_in;
      #3 sclk_out = 1'b0;
    end
    #3 cs_n_out = 1'b1;
    sda_out = ~sda_out;
  endtask
endmodule

// >>> tb.sv
// Testbench of the serial gain-control block.
`timescale 1ns/10ps
module tb;
  import pgc_pkg::*;
  logic clock_in, rst_in, te, sclk, cs_n, h_d, sda, d_out, oe_n, pw, pulse;
  logic [5:0] gain;
  logic [1:0] pwr;
  logic [7:0] bias, q;
  logic [7:0] tv [4] = '{8'h3F, 8'h40, 8'h95, 8'hEA};
  int bad_count = 0;
  int check_count = 0;
  assign sda = oe_n ? h_d : d_out;
  pgc_serial_gain_control dut (.clock_in(clock_in), .rst_in(rst_in), .serial_clock_in(sclk),
    .chip_select_n_in(cs_n), .serial_data_in(sda), .serial_data_out(d_out),
    .serial_data_oe_n_out(oe_n), .transmit_enable_in(te), .gain_code_out(gain),
    .power_code_out(pwr), .bias_level_out(bias), .amp_powered_out(pw),
    .update_pulse_out(pulse));
  pgc_host host (.sclk_out(sclk), .cs_n_out(cs_n), .sda_out(h_d), .sda_in(sda));
  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wait_pulse(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (40)
    begin
      cyc(1);
      if (pulse === 1'b1)
        seen = 1'b1;
    end
    chk("update pulse", {7'h00, e}, {7'h00, seen});
    if (seen !== e)
      close_out();
  endtask
  task automatic t_reset;
    chk("setting", PGC_GAIN_POWER_RESET, {pwr, gain});
    chk("bias", 8'h00, bias);
    chk("released", 8'h01, {7'h00, oe_n});
    $display("test reset done");
  endtask
  task automatic t_write(input logic [7:0] v);
    host.frame(1'b0, PGC_ADDR_GAIN_POWER, v, 12, q);
    wait_pulse(1'b1);
    chk("setting", v, {pwr, gain});
    host.frame(1'b1, PGC_ADDR_GAIN_POWER, 8'h00, 12, q);
    chk("read data", v, q);
    cyc(1);
    te = 1'b1;
    cyc(8);
    chk("powered", 8'h01, {7'h00, pw});
    chk("bias", v, bias);
    te = 1'b0;
    cyc(8);
    chk("bias", 8'h00, bias);
    $display("test write %h done", v);
  endtask
  task automatic t_refuse;
    logic [7:0] v;
    v = {pwr, gain};
    host.frame(1'b0, PGC_ADDR_GAIN_POWER, ~v, 11, q);
    wait_pulse(1'b0);
    host.frame(1'b0, 3'h5, ~v, 12, q);
    wait_pulse(1'b0);
    chk("setting", v, {pwr, gain});
    host.frame(1'b1, 3'h5, 8'h00, 12, q);
    chk("unmapped read", PGC_UNMAPPED_READ, q);
    $display("test refuse done");
  endtask
  initial
  begin
    rst_in = 1'b1;
    te = 1'b0;
    fork
      cyc(6);
      host.idle_clocks(3);
    join
    rst_in = 1'b0;
    host.idle_clocks(3);
    t_reset();
    #100000;
    cyc(1);
    foreach (tv[i])
      t_write(tv[i]);
    t_refuse();
    close_out();
  end
endmodule
